// >>> rtl/snvm_pkg.sv
// Purpose: Shared constants and types of the serial nonvolatile memory slave.
// Assumes: One system clock; serial pins are sampled by it.
// Notes: Opcodes, status layout and counts live here.
package snvm_pkg;
    localparam int SNVM_DEPTH = 2048;
    localparam int SNVM_AW = 11;
    localparam int SNVM_DW = 8;
    localparam int SNVM_ADDR_BITS = 16;
    localparam logic [2:0] SNVM_BIT_LAST = 3'h7;
    localparam logic [7:0] SNVM_OP_LATCH_SET = 8'h06;
    localparam logic [7:0] SNVM_OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] SNVM_OP_STAT_RD = 8'h05;
    localparam logic [7:0] SNVM_OP_STAT_WR = 8'h01;
    localparam logic [7:0] SNVM_OP_ARR_RD = 8'h03;
    localparam logic [7:0] SNVM_OP_ARR_WR = 8'h02;
    localparam logic [7:0] SNVM_OP_ID_RD = 8'h9f;
    localparam int SNVM_ST_LOCK = 7;
    localparam int SNVM_ST_LATCH = 1;
    localparam logic [7:0] SNVM_ST_WR_MASK = 8'hfc;
    localparam logic [7:0] SNVM_ST_RST = 8'h00;
    // Identity bytes: values are arbitrary.
    localparam logic [31:0] SNVM_ID_DEFAULT = 32'h5a_01_02_03;

    typedef enum logic [2:0] {
        SNVM_OPCODE,
        SNVM_ADDR,
        SNVM_WDATA,
        SNVM_RDATA,
        SNVM_STWR,
        SNVM_STRD,
        SNVM_IDRD,
        SNVM_IDLE
    } snvm_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } snvm_pins_t;
endpackage

// >>> rtl/snvm_mem.sv
// Purpose: Byte array with registered read data.
// Assumes: Single port, write and read share the address.
// Notes: Contents survive reset, as a nonvolatile store would.
`timescale 1ns/100ps
module snvm_mem
    import snvm_pkg::*;
#(
    parameter int DEPTH = SNVM_DEPTH,
    parameter int AW = SNVM_AW,
    parameter int DW = SNVM_DW
)(
    input wire logic mclk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_ff [DEPTH];

    always_ff @(posedge mclk_i)
    begin
        if (ce_i)
        begin
            if (we_i)
            begin
                mem_ff[addr_i] <= wdata_i;
            end
            rdata_o <= mem_ff[addr_i];
        end
    end
endmodule

// >>> rtl/snvm_slave.sv
// Purpose: Serial slave front end of a 2,048 x 8 nonvolatile byte memory.
// Assumes: Pins are oversampled by mclk_i, well above twice the serial rate.
// Notes: Serial output pin is given as data plus active-low output enable.
// Behaviour
// - Array holds 2,048 bytes of eight bits.
// - Array writes finish at once, never busy.
// - Select high: standby, output floats, inputs ignored.
// - Hold pauses transfer without deselecting device.
// - Hold low: output floats, clock, input ignored.
// - Sample on rising edge, shift out falling.
// - Output carries array, status or identity read data.
// - Works in clock modes zero and three.
// - Protect pin and lock bit block status writes.
// - Decode seven opcodes; aborted opcode never executes.
// - Status layout: lock, spare, guards, latch, zero.
// - Latch cleared at reset, clear command, write end.
// - Sixteen-bit address, auto increment, wrap to zero.
`timescale 1ns/100ps
module snvm_slave
    import snvm_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = SNVM_ID_DEFAULT
)(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    output logic [7:0] status_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when stages two and three agree.
    snvm_pins_t raw_pins;
    snvm_pins_t s1_ff;
    snvm_pins_t s2_ff;
    snvm_pins_t s3_ff;
    snvm_pins_t pin_ff;
    assign raw_pins = '{cs_n: cs_n_i, sck: sck_i, si: si_i, hold_n: hold_n_i, wp_n: wp_n_i};

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
            s2_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
            s3_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
            pin_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
        end
        else if (ce_i)
        begin
            s1_ff <= raw_pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= (s2_ff == s3_ff) ? s3_ff : pin_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Edge detection on the filtered pins.
    logic sck_prev_ff;
    logic cs_prev_ff;
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sck_prev_ff <= 1'b0;
            cs_prev_ff <= 1'b1;
        end
        else if (ce_i)
        begin
            sck_prev_ff <= pin_ff.sck;
            cs_prev_ff <= pin_ff.cs_n;
        end
    end

    wire selected = !pin_ff.cs_n;
    wire active = selected && pin_ff.hold_n;
    wire sck_rise = active && pin_ff.sck && !sck_prev_ff;
    wire sck_fall = active && !pin_ff.sck && sck_prev_ff;
    wire cs_rise = pin_ff.cs_n && !cs_prev_ff;
    wire cs_fall = !pin_ff.cs_n && cs_prev_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Command state.
    snvm_state_t state_ff, nxt_state;
    logic [2:0] bit_ff;
    logic [7:0] shin_ff;
    logic [7:0] shout_ff;
    logic [SNVM_ADDR_BITS-1:0] addr_ff;
    logic [1:0] id_idx_ff;
    logic latch_ff;
    logic [7:0] stat_nv_ff;
    logic wrote_ff;
    logic so_ff;
    logic rd_pend_ff;

    wire [7:0] byte_in = {shin_ff[6:0], pin_ff.si};
    wire byte_done = sck_rise && (bit_ff == SNVM_BIT_LAST);
    wire [SNVM_AW-1:0] arr_addr = addr_ff[SNVM_AW-1:0];
    wire [SNVM_ADDR_BITS-1:0] addr_next = {addr_ff[SNVM_ADDR_BITS-SNVM_DW-1:0], byte_in};
    wire [SNVM_AW-1:0] addr_inc = arr_addr + 1'b1;
    wire [7:0] status_rd = {stat_nv_ff[7:2], latch_ff, 1'b0};
    wire stat_locked = stat_nv_ff[SNVM_ST_LOCK] && !pin_ff.wp_n;
    wire arr_we = (state_ff == SNVM_WDATA) && byte_done && latch_ff;
    wire [7:0] id_byte = ID_VALUE[8'(31 - 8 * id_idx_ff) -: 8];
    logic [7:0] mem_rdata;

    always_comb
    begin
        nxt_state = state_ff;
        if (byte_done)
        begin
            case (state_ff)
                SNVM_OPCODE:
                begin
                    case (byte_in)
                        SNVM_OP_STAT_RD: nxt_state = SNVM_STRD;
                        SNVM_OP_STAT_WR: nxt_state = SNVM_STWR;
                        SNVM_OP_ARR_RD: nxt_state = SNVM_ADDR;
                        SNVM_OP_ARR_WR: nxt_state = SNVM_ADDR;
                        SNVM_OP_ID_RD: nxt_state = SNVM_IDRD;
                        default: nxt_state = SNVM_IDLE;
                    endcase
                end
                SNVM_ADDR:
                begin
                    if (id_idx_ff[0])
                    begin
                        nxt_state = rd_pend_ff ? SNVM_RDATA : SNVM_WDATA;
                    end
                end
                SNVM_STWR: nxt_state = SNVM_IDLE;
                default: nxt_state = state_ff;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= SNVM_OPCODE;
            bit_ff <= 3'h0;
            shin_ff <= 8'h00;
            shout_ff <= 8'h00;
            addr_ff <= '0;
            id_idx_ff <= 2'h0;
            latch_ff <= 1'b0;
            stat_nv_ff <= SNVM_ST_RST;
            wrote_ff <= 1'b0;
            so_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (cs_rise || cs_fall)
            begin
                state_ff <= SNVM_OPCODE;
                bit_ff <= 3'h0;
                id_idx_ff <= 2'h0;
                if (cs_rise && wrote_ff)
                begin
                    latch_ff <= 1'b0;
                end
                wrote_ff <= 1'b0;
            end
            else if (sck_rise)
            begin
                state_ff <= nxt_state;
                bit_ff <= bit_ff + 3'h1;
                shin_ff <= byte_in;
                if (byte_done)
                begin
                    case (state_ff)
                        SNVM_OPCODE:
                        begin
                            rd_pend_ff <= (byte_in == SNVM_OP_ARR_RD);
                            wrote_ff <= (byte_in == SNVM_OP_ARR_WR) ||
                                (byte_in == SNVM_OP_STAT_WR);
                            if (byte_in == SNVM_OP_LATCH_SET)
                            begin
                                latch_ff <= 1'b1;
                            end
                            if (byte_in == SNVM_OP_LATCH_CLR)
                            begin
                                latch_ff <= 1'b0;
                            end
                            shout_ff <= status_rd;
                            id_idx_ff <= 2'h0;
                        end
                        SNVM_ADDR:
                        begin
                            addr_ff <= addr_next;
                            id_idx_ff <= id_idx_ff + 2'h1;
                        end
                        SNVM_STWR:
                        begin
                            if (latch_ff && !stat_locked)
                            begin
                                stat_nv_ff <= byte_in & SNVM_ST_WR_MASK;
                            end
                        end
                        SNVM_WDATA: addr_ff <= SNVM_ADDR_BITS'(addr_inc);
                        SNVM_RDATA: addr_ff <= SNVM_ADDR_BITS'(addr_inc);
                        SNVM_STRD: shout_ff <= status_rd;
                        SNVM_IDRD: id_idx_ff <= id_idx_ff + 2'h1;
                        default: shout_ff <= shout_ff;
                    endcase
                end
            end
            else if (sck_fall)
            begin
                case (state_ff)
                    SNVM_RDATA: so_ff <= (bit_ff == 3'h0) ? mem_rdata[7] : shout_ff[7];
                    SNVM_STRD: so_ff <= (bit_ff == 3'h0) ? status_rd[7] : shout_ff[7];
                    SNVM_IDRD: so_ff <= (bit_ff == 3'h0) ? id_byte[7] : shout_ff[7];
                    default: so_ff <= 1'b0;
                endcase
                case (state_ff)
                    SNVM_RDATA: shout_ff <= (bit_ff == 3'h0) ? {mem_rdata[6:0], 1'b0}
                        : {shout_ff[6:0], 1'b0};
                    SNVM_STRD: shout_ff <= (bit_ff == 3'h0) ? {status_rd[6:0], 1'b0}
                        : {shout_ff[6:0], 1'b0};
                    SNVM_IDRD: shout_ff <= (bit_ff == 3'h0) ? {id_byte[6:0], 1'b0}
                        : {shout_ff[6:0], 1'b0};
                    default: shout_ff <= shout_ff;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte array, read data registered.
    snvm_mem #(
        .DEPTH(SNVM_DEPTH),
        .AW(SNVM_AW),
        .DW(SNVM_DW)
    ) u_mem (
        .mclk_i(mclk_i),
        .ce_i(ce_i),
        .we_i(arr_we),
        .addr_i(arr_addr),
        .wdata_i(byte_in),
        .rdata_o(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Output pin: enable low only while selected, not held, and reading.
    wire reading = (state_ff == SNVM_RDATA) || (state_ff == SNVM_STRD) ||
        (state_ff == SNVM_IDRD);
    assign so_o = so_ff;
    assign so_oe_n_o = !(active && reading);
    assign status_o = status_rd;
endmodule

// >>> dv/snvm_slave_chk.sv
// Purpose: Assertions on the serial memory slave ports.
// Assumes: Pins settle through the slave's input pipeline within 8 mclk.
// Notes: Bound to every snvm_slave instance.
`timescale 1ns/100ps
module snvm_slave_chk(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    input wire logic so_o,
    input wire logic so_oe_n_o,
    input wire logic [7:0] status_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    chk_cs_float: assert property (cs_n_i [*8] |-> so_oe_n_o)
        else $error("output driven while deselected");
    chk_hold_float: assert property ((!hold_n_i) [*8] |-> so_oe_n_o)
        else $error("output driven during hold");
    chk_zero_bit: assert property (!status_o[0])
        else $error("status bit zero set");
    chk_idle_status: assert property (cs_n_i [*8] |-> $stable(status_o))
        else $error("status changed while deselected");
    chk_so_quiet: assert property ((!cs_n_i && hold_n_i && $stable(sck_i)) [*8]
        |-> $stable(so_o))
        else $error("output moved without a clock edge");
    chk_ce_freeze: assert property (!ce_i |=> $stable(status_o) && $stable(so_o))
        else $error("state moved with clock enable low");
    chk_latch_guard: assert property ($changed(status_o[7:2]) |-> $past(status_o[1]))
        else $error("status written without write latch");
    chk_lock_pin: assert property ($changed(status_o[7:2])
        |-> !$past(status_o[7]) || $past(wp_n_i))
        else $error("status written while locked");
    cover property (!so_oe_n_o);
    cover property ($changed(status_o[7:2]));
    cover property ((!hold_n_i && !cs_n_i) [*8]);
endmodule
bind snvm_slave snvm_slave_chk i_snvm_slave_chk(.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i),
    .so_o(so_o), .so_oe_n_o(so_oe_n_o), .status_o(status_o));

// >>> dv/snvm_host.sv
// Purpose: Serial host model driving select, clock, data and hold.
// Assumes: Half period of 10 mclk; pins change at falling mclk.
// Notes: A floating output reads as the inverse of its last bit.
`timescale 1ns/100ps
module snvm_host(
    input wire logic mclk_i,
    input wire logic so_i,
    input wire logic so_oe_n_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    output logic hold_n_o
);
    logic m3 = 1'b0;
    logic last = 1'b0;
    initial {cs_n_o, sck_o, si_o, hold_n_o} = 4'h9;
    task automatic w(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic sel(input logic m);
        m3 = m;
        sck_o = m;
        w(10);
        cs_n_o = 1'b0;
        w(10);
    endtask
    task automatic desel();
        w(10);
        cs_n_o = 1'b1;
        w(20);
    endtask
    task automatic xb(input logic [7:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            if (m3)
                sck_o = 1'b0;
            si_o = d[i];
            w(10);
            sck_o = 1'b1;
            last = so_oe_n_i ? ~last : so_i;
            q = {q[6:0], last};
            w(10);
            if (!m3)
                sck_o = 1'b0;
        end
    endtask
    task automatic pause();
        w(10);
        hold_n_o = 1'b0;
        w(10);
        repeat (4)
        begin
            sck_o = ~sck_o;
            si_o = ~si_o;
            w(10);
        end
        hold_n_o = 1'b1;
        w(10);
    endtask
endmodule

// >>> dv/snvm_slave_test.sv
// Purpose: Self-checking bench of the serial memory slave.
// Assumes: Host model does the pin timing.
// Notes: Array contents carry over from one case to the next.
`timescale 1ns/100ps
module snvm_slave_test;
    import snvm_pkg::*;
    typedef struct packed {logic [15:0] wa; logic [15:0] ra; logic [7:0] d; logic m;} snvm_row_t;
    snvm_row_t rows [4] = '{'{16'h0000, 16'h0000, 8'ha5, 1'b0}, '{16'hf812, 16'h0012, 8'h3c, 1'b1},
        '{16'h07ff, 16'hffff, 8'h5e, 1'b0}, '{16'h0400, 16'h0400, 8'hc3, 1'b1}};
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic wp_n = 1'b1;
    logic so, so_oe_n, cs_n, sck, si, hold_n;
    logic [7:0] status, q;
    logic [31:0] id = SNVM_ID_DEFAULT;
    int err_count = 0;
    int n_compared = 0;
    snvm_slave i_snvm_slave(.mclk_i(mclk), .nrst_i(nrst), .ce_i(ce), .cs_n_i(cs_n), .sck_i(sck),
        .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so), .so_oe_n_o(so_oe_n),
        .status_o(status));
    snvm_host i_snvm_host(.mclk_i(mclk), .so_i(so), .so_oe_n_i(so_oe_n), .cs_n_o(cs_n),
        .sck_o(sck), .si_o(si), .hold_n_o(hold_n));
    initial forever #10 mclk = ~mclk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic xb(input logic [7:0] d);
        i_snvm_host.xb(d, 8, q);
    endtask
    task automatic go(input logic [7:0] op, input logic m);
        i_snvm_host.sel(m);
        xb(op);
    endtask
    task automatic one(input logic [7:0] op);
        go(op, 1'b0);
        i_snvm_host.desel();
    endtask
    task automatic acc(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d,
        input logic m);
        go(op, m);
        xb(a[15:8]);
        xb(a[7:0]);
        xb(d);
    endtask
    task automatic swr(input logic [7:0] d);
        one(SNVM_OP_LATCH_SET);
        go(SNVM_OP_STAT_WR, 1'b0);
        xb(d);
        i_snvm_host.desel();
    endtask
    initial
    begin
        repeat (100000) @(posedge mclk);
        err_count++;
        finish_test();
    end
    initial
    begin
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        repeat (5) @(negedge mclk);
        chk(status, SNVM_ST_RST);
        chk(so_oe_n, 1'b1);
        foreach (rows[k])
        begin
            one(SNVM_OP_LATCH_SET);
            acc(SNVM_OP_ARR_WR, rows[k].wa, rows[k].d, rows[k].m);
            i_snvm_host.desel();
            chk(status[1], 1'b0);
            acc(SNVM_OP_ARR_RD, rows[k].ra, 8'h00, rows[k].m);
            i_snvm_host.desel();
            chk(q, rows[k].d);
        end
        one(SNVM_OP_LATCH_SET);
        one(SNVM_OP_LATCH_CLR);
        chk(status[1], 1'b0);
        acc(SNVM_OP_ARR_WR, 16'h0000, 8'hee, 1'b0);
        i_snvm_host.desel();
        acc(SNVM_OP_ARR_RD, 16'h0000, 8'h00, 1'b0);
        i_snvm_host.desel();
        chk(q, 8'ha5);
        i_snvm_host.sel(1'b0);
        i_snvm_host.xb(SNVM_OP_LATCH_SET, 7, q);
        i_snvm_host.desel();
        chk(status[1], 1'b0);
        one(SNVM_OP_LATCH_SET);
        acc(SNVM_OP_ARR_WR, 16'h07ff, 8'h11, 1'b0);
        xb(8'h22);
        i_snvm_host.desel();
        acc(SNVM_OP_ARR_RD, 16'h87ff, 8'h00, 1'b1);
        chk(q, 8'h11);
        xb(8'h00);
        i_snvm_host.desel();
        chk(q, 8'h22);
        go(SNVM_OP_ARR_RD, 1'b0);
        xb(8'h00);
        i_snvm_host.pause();
        xb(8'h00);
        i_snvm_host.pause();
        xb(8'h00);
        i_snvm_host.desel();
        chk(q, 8'h22);
        swr(8'hff);
        chk(status, 8'hfc);
        go(SNVM_OP_STAT_RD, 1'b1);
        xb(8'h00);
        chk(q, 8'hfc);
        chk(so_oe_n, 1'b0);
        xb(8'h00);
        i_snvm_host.desel();
        chk(q, 8'hfc);
        wp_n = 1'b0;
        swr(8'h00);
        chk(status, 8'hfc);
        wp_n = 1'b1;
        swr(8'h00);
        chk(status, 8'h00);
        go(SNVM_OP_STAT_WR, 1'b0);
        xb(8'hff);
        i_snvm_host.desel();
        chk(status, 8'h00);
        go(SNVM_OP_ID_RD, 1'b1);
        for (int j = 0; j < 4; j++)
        begin
            xb(8'h00);
            chk(q, id[31 - 8 * j -: 8]);
        end
        i_snvm_host.desel();
        go(8'h55, 1'b0);
        xb(8'h00);
        chk(so_oe_n, 1'b1);
        i_snvm_host.desel();
        ce = 1'b0;
        repeat (20) @(negedge mclk);
        ce = 1'b1;
        finish_test();
    end
endmodule
